// file: rtl/ssf_status.sv
// serial unit with status flags, shifter, and receive fifo
module ssf_status
    import ssf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic btu_tx_write,
    input wire logic btu_rx_read,
    input wire logic btu_sel,
    input wire logic [7:0] btu_wdata,
    output logic [7:0] btu_rdata,
    input wire logic miso,
    output logic mosi,
    output logic sck,
    output logic tx_empty_request,
    output logic rx_full_request,
    output logic tx_end_request
);
    logic [7:0] enable_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] tx_holding_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_word_reg;
    logic rx_word_valid_reg;
    logic transmit_end_flag_reg;
    logic tx_buffer_empty_flag_reg;
    logic rx_buffer_full_flag_reg;
    logic ce_flag_reg;
    logic seen_end_reg;
    logic seen_empty_reg;
    logic seen_full_reg;
    logic miso_s1_reg;
    logic miso_s2_reg;
    ssf_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] half_cnt_reg;
    logic sck_reg;
    logic mosi_reg;
    logic [7:0] rdata_reg;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic transmit_enable_bit;
    logic timing_sel;
    logic tx_write;
    logic load_shift;
    logic last_bit;
    logic shift_done;
    logic status_wr;
    logic status_rd;
    logic rx_read;
    logic half_tick;
    ssf_fifo_if #(.W(DATA_W)) rxs ();

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign transmit_enable_bit = enable_reg[BIT_TE];
    assign timing_sel = ctrl2_reg[BIT_TIMSEL];
    assign status_wr = wr && hit(addr, OFS_STATUS);
    assign status_rd = rd && hit(addr, OFS_STATUS);
    assign tx_write = (wr && hit(addr, OFS_TXDATA)) ||
        (btu_tx_write && !btu_sel);
    assign rx_read = (rd && hit(addr, OFS_RXDATA)) ||
        (btu_rx_read && !btu_sel);
    assign fifo_pop = rx_read && fifo_valid;
    assign half_tick = (half_cnt_reg == 8'(SCK_HALF_CYC - 1));
    assign load_shift = (state_reg == SSF_IDLE) && transmit_enable_bit &&
        !tx_buffer_empty_flag_reg;
    assign last_bit = (state_reg == SSF_SHIFT) &&
        (bit_cnt_reg == 4'(BITS_PER_WORD - 1));
    assign shift_done = (state_reg == SSF_TAIL) && half_tick;
    assign sck = sck_reg;
    assign mosi = mosi_reg;
    assign rdata = rdata_reg;
    assign btu_rdata = fifo_data;
    assign tx_empty_request = tx_buffer_empty_flag_reg &&
        enable_reg[BIT_TIE];
    assign rx_full_request = rx_buffer_full_flag_reg &&
        enable_reg[BIT_RIE];
    assign tx_end_request = transmit_end_flag_reg &&
        enable_reg[BIT_TEIE];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
        end else begin
            miso_s1_reg <= miso;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_reg <= RST_ENABLE;
            ctrl2_reg <= RST_CTRL2;
            tx_holding_reg <= 8'h00;
        end else begin
            if (wr && hit(addr, OFS_ENABLE)) begin
                enable_reg <= wdata & 8'hCF;
            end
            if (wr && hit(addr, OFS_CTRL2)) begin
                ctrl2_reg <= wdata & 8'h1C;
            end
            if (wr && hit(addr, OFS_TXDATA)) begin
                tx_holding_reg <= wdata;
            end else if (btu_tx_write) begin
                tx_holding_reg <= btu_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SSF_IDLE;
            bit_cnt_reg <= 4'h0;
            half_cnt_reg <= 8'h00;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            shift_reg <= 8'h00;
            rx_word_reg <= 8'h00;
            rx_word_valid_reg <= 1'b0;
        end else begin
            if (rxs.ready) begin
                rx_word_valid_reg <= 1'b0;
            end
            half_cnt_reg <= (state_reg == SSF_IDLE || half_tick) ?
                8'h00 : half_cnt_reg + 8'h01;
            case (state_reg)
                SSF_IDLE: begin
                    if (load_shift) begin
                        shift_reg <= tx_holding_reg;
                        mosi_reg <= tx_holding_reg[7];
                        bit_cnt_reg <= 4'h0;
                        state_reg <= SSF_SHIFT;
                    end
                end
                SSF_SHIFT: begin
                    if (half_tick) begin
                        sck_reg <= !sck_reg;
                        if (sck_reg) begin
                            mosi_reg <= shift_reg[7];
                            if (last_bit) begin
                                state_reg <= SSF_TAIL;
                            end
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else begin
                            shift_reg <= {shift_reg[6:0], miso_s2_reg};
                        end
                    end
                end
                SSF_TAIL: begin
                    if (half_tick) begin
                        state_reg <= SSF_IDLE;
                        if (enable_reg[BIT_RE] && !rx_word_valid_reg) begin
                            rx_word_reg <= shift_reg;
                            rx_word_valid_reg <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= SSF_IDLE;
                end
            endcase
        end
    end

    assign rxs.valid = rx_word_valid_reg;
    assign rxs.data = rx_word_reg;

    ssf_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_s(rxs),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // transmit end flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transmit_end_flag_reg <= RST_TXEND;
            seen_end_reg <= 1'b0;
        end else begin
            if (status_rd && transmit_end_flag_reg) begin
                seen_end_reg <= 1'b1;
            end
            if (tx_buffer_empty_flag_reg && !load_shift &&
                ((!timing_sel && last_bit) ||
                 (timing_sel && shift_done))) begin
                transmit_end_flag_reg <= 1'b1;
                seen_end_reg <= 1'b0;
            end else if (tx_write) begin
                transmit_end_flag_reg <= 1'b0;
                seen_end_reg <= 1'b0;
            end else if (status_wr && !wdata[BIT_TXEND] && seen_end_reg) begin
                transmit_end_flag_reg <= 1'b0;
                seen_end_reg <= 1'b0;
            end
        end
    end

    // transmit buffer empty flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_buffer_empty_flag_reg <= RST_TXEMPTY;
            seen_empty_reg <= 1'b0;
        end else begin
            if (status_rd && tx_buffer_empty_flag_reg) begin
                seen_empty_reg <= 1'b1;
            end
            if (!transmit_enable_bit) begin
                tx_buffer_empty_flag_reg <= 1'b1;
            end else if (load_shift) begin
                tx_buffer_empty_flag_reg <= 1'b1;
                seen_empty_reg <= 1'b0;
            end else if (tx_write) begin
                tx_buffer_empty_flag_reg <= 1'b0;
                seen_empty_reg <= 1'b0;
            end else if (status_wr && !wdata[BIT_TXEMPTY] &&
                seen_empty_reg) begin
                tx_buffer_empty_flag_reg <= 1'b0;
                seen_empty_reg <= 1'b0;
            end
        end
    end

    // receive buffer full flag sets on each fifo push, clears on a receive read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_buffer_full_flag_reg <= RST_RXFULL;
            seen_full_reg <= 1'b0;
        end else begin
            if (status_rd && rx_buffer_full_flag_reg) begin
                seen_full_reg <= 1'b1;
            end
            if (rxs.valid && rxs.ready) begin
                rx_buffer_full_flag_reg <= 1'b1;
                seen_full_reg <= 1'b0;
            end else if (rx_read) begin
                rx_buffer_full_flag_reg <= 1'b0;
                seen_full_reg <= 1'b0;
            end else if (status_wr && !wdata[BIT_RXFULL] && seen_full_reg) begin
                rx_buffer_full_flag_reg <= 1'b0;
                seen_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ce_flag_reg <= 1'b0;
        end else if (status_wr && !wdata[BIT_CE]) begin
            ce_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (rd) begin
            case (addr)
                OFS_STATUS: rdata_reg <= {4'h0, transmit_end_flag_reg,
                    tx_buffer_empty_flag_reg || !transmit_enable_bit,
                    rx_buffer_full_flag_reg,
                    ce_flag_reg};
                OFS_ENABLE: rdata_reg <= enable_reg;
                OFS_CTRL2: rdata_reg <= ctrl2_reg;
                OFS_TXDATA: rdata_reg <= tx_holding_reg;
                OFS_RXDATA: rdata_reg <= fifo_data;
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
endmodule : ssf_status

// file: pkg/ssf_pkg.sv
// package of constants and types for the serial status flag block
// Function
// - timing select 0, buffer empty: set transmit end while last bit shifts.
// - timing select 1, buffer empty: set transmit end after last bit done.
// - transmit end clears on write 0 after read 1, or on holding write.
// - buffer empty flag is bit 2, resets to 1, shows holding register empty.
// - buffer empty flag forced to 1 while transmit enable is 0.
// - buffer empty flag sets when holding word moves into shift register.
// - buffer empty flag clears on write 0 after it was read as 1.
// - buffer empty flag clears on holding write while transmit enabled.
// - block transfer write from transmit request, select 0, clears empty.
// - receive full flag is bit 1, resets to 0, shows unread data.
// - receive full flag sets when received word copied to holding register.
// - receive full flag clears on write 0 after it was read as 1.
// - any read of receive holding register clears receive full flag; here a fifo push in the same cycle wins and the flag stays set.
// - block transfer read from receive request, select 0, clears full flag.
// - transmit enable 1 permits transmission; 0 disables it.
// - transmit empty request issued only while its interrupt enable is 1.
package ssf_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_ENABLE = 4'h1;
    localparam logic [3:0] OFS_CTRL2 = 4'h2;
    localparam logic [3:0] OFS_TXDATA = 4'h3;
    localparam logic [3:0] OFS_RXDATA = 4'h4;
    localparam int BIT_CE = 0;
    localparam int BIT_RXFULL = 1;
    localparam int BIT_TXEMPTY = 2;
    localparam int BIT_TXEND = 3;
    localparam int BIT_TE = 7;
    localparam int BIT_RE = 6;
    localparam int BIT_TEIE = 3;
    localparam int BIT_TIE = 2;
    localparam int BIT_RIE = 1;
    localparam int BIT_CEIE = 0;
    localparam int BIT_TIMSEL = 4;
    localparam logic RST_TXEMPTY = 1'b1;
    localparam logic RST_TXEND = 1'b0;
    localparam logic RST_RXFULL = 1'b0;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam int FIFO_DEPTH = 16;
    localparam int DATA_W = 8;
    localparam int BITS_PER_WORD = 8;
    localparam int SCK_HALF_NS = 40;
    localparam int CLK_NS = 10;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {SSF_IDLE, SSF_SHIFT, SSF_TAIL} ssf_state_e;
endpackage : ssf_pkg

// file: pkg/ssf_fifo_if.sv
// stream interface between the receive shifter and the receive fifo
interface ssf_fifo_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ssf_fifo_if

// file: rtl/ssf_fifo.sv
// parameterised fifo with valid and ready on both sides
module ssf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    ssf_fifo_if.snk in_s,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_s.ready = (cnt_reg != (AW+1)'(DEPTH)) || pop;
    assign out_valid = (cnt_reg != '0);
    assign push = in_s.valid && in_s.ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wp_reg] <= in_s.data;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_data <= '0;
        end else if (push && (cnt_reg == '0 ||
            (pop && cnt_reg == (AW+1)'(1)))) begin
            out_data <= in_s.data;
        end else if (pop) begin
            out_data <= mem_reg[rp_reg + 1'b1];
        end
    end
endmodule : ssf_fifo

// file: tb/ssf_partner.sv
// behavioural model of the external serial device on the link
module ssf_partner (
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] in_reg;
    int cnt;
    int idx;
    initial begin
        in_reg = 8'h00;
        rx_byte = 8'h00;
        cnt = 0;
        idx = 0;
    end
    // msb first: sample on the rising edge, next bit after the falling one
    always @(posedge sck) begin
        in_reg = {in_reg[6:0], mosi};
        cnt = cnt + 1;
        if (cnt == 8) begin
            rx_byte = in_reg;
            cnt = 0;
        end
    end
    always @(negedge sck) begin
        idx = cnt;
    end
    assign miso = tx_byte[7 - idx];
endmodule : ssf_partner

// file: tb/ssf_status_properties.sv
// concurrent checks on the ports of the serial status flag block
module ssf_status_properties
    import ssf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic btu_tx_write,
    input wire logic btu_rx_read,
    input wire logic btu_sel,
    input wire logic sck,
    input wire logic tx_empty_request,
    input wire logic rx_full_request,
    input wire logic tx_end_request
);
    logic [7:0] en_reg;
    // shadow of the enable register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_reg <= RST_ENABLE;
        end else if (wr && addr == OFS_ENABLE) begin
            en_reg <= wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    tx_req_gated_a:
        assert property (tx_empty_request |-> en_reg[BIT_TIE])
        else $error("transmit request without its enable");
    rx_req_gated_a:
        assert property (rx_full_request |-> en_reg[BIT_RIE])
        else $error("receive request without its enable");
    end_req_gated_a:
        assert property (tx_end_request |-> en_reg[BIT_TEIE])
        else $error("end request without its enable");
    empty_forced_a:
        assert property (rd && addr == OFS_STATUS && !en_reg[BIT_TE]
            |=> rdata[BIT_TXEMPTY])
        else $error("empty flag not forced while disabled");
    load_clears_a:
        assert property (wr && addr == OFS_TXDATA && en_reg[BIT_TE]
            && en_reg[BIT_TIE] |=> !tx_empty_request)
        else $error("holding write left empty flag set");
    write_ends_a:
        assert property (wr && addr == OFS_TXDATA && en_reg[BIT_TEIE]
            |=> !tx_end_request)
        else $error("holding write left end flag set");
    rx_read_a:
        assert property (rd && addr == OFS_RXDATA |=> !rx_full_request)
        else $error("receive read left full flag set");
    btu_read_a:
        assert property (btu_rx_read && !btu_sel |=> !rx_full_request)
        else $error("transfer read left full flag set");
    btu_write_a:
        assert property (btu_tx_write && !btu_sel && en_reg[BIT_TE]
            && en_reg[BIT_TIE] |=> !tx_empty_request)
        else $error("transfer write left empty flag set");
    sck_idle_a:
        assert property (!en_reg[BIT_TE] && !sck |=> !sck)
        else $error("serial clock ran while disabled");
    cover property ($rose(tx_end_request));
    cover property ($rose(rx_full_request));
    cover property (btu_tx_write && !btu_sel);
endmodule : ssf_status_properties

bind ssf_status ssf_status_properties i_ssf_status_properties (.clk(clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .btu_tx_write(btu_tx_write), .btu_rx_read(btu_rx_read),
    .btu_sel(btu_sel), .sck(sck), .tx_empty_request(tx_empty_request),
    .rx_full_request(rx_full_request), .tx_end_request(tx_end_request));

// file: tb/tb.sv
// self-checking testbench for the serial status flag block
module tb;
    import ssf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, wr, rd, btu_tx_write, btu_rx_read, btu_sel;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata, btu_wdata, btu_rdata, peer_tx, peer_rx;
    logic miso, mosi, sck, tx_empty_request, rx_full_request, tx_end_request;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int dt [2];
    ssf_status i_ssf_status (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
        .btu_tx_write, .btu_rx_read, .btu_sel, .btu_wdata, .btu_rdata,
        .miso, .mosi, .sck, .tx_empty_request, .rx_full_request,
        .tx_end_request);
    ssf_partner i_ssf_partner (.sck, .mosi, .miso, .tx_byte(peer_tx),
        .rx_byte(peer_rx));
    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask : rd_chk
    task automatic btu_pulse(input logic tx, input logic [7:0] d);
        @(posedge clk);
        btu_wdata <= d;
        btu_tx_write <= tx;
        btu_rx_read <= ~tx;
        @(posedge clk);
        btu_tx_write <= 1'b0;
        btu_rx_read <= 1'b0;
    endtask : btu_pulse
    // cycles to the end flag, then wait for the received word
    task automatic frame_wait(output int t_end);
        int n;
        n = 0;
        while (tx_end_request !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        t_end = n;
        while (rx_full_request !== 1'b1 && n < 800) begin
            @(posedge clk);
            n++;
        end
        @(negedge clk);
    endtask : frame_wait
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        resetn = 1'b0;
        addr = '0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        btu_tx_write = 1'b0;
        btu_rx_read = 1'b0;
        btu_sel = 1'b0;
        btu_wdata = 8'h00;
        peer_tx = 8'h3C;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(OFS_STATUS, 8'h04);
        rd_chk(OFS_ENABLE, RST_ENABLE);
        rd_chk(4'hF, 8'h00);
        wr_reg(OFS_STATUS, 8'h00);
        rd_chk(OFS_STATUS, 8'h04);
        wr_reg(OFS_ENABLE, 8'hCE);
        @(negedge clk);
        check({7'h00, tx_empty_request}, 8'h01);
        for (int s = 0; s < 2; s++) begin
            wr_reg(OFS_CTRL2, s[0] ? 8'h10 : 8'h00);
            wr_reg(OFS_TXDATA, 8'hA5);
            frame_wait(dt[s]);
            check(peer_rx, 8'hA5);
            rd_chk(OFS_STATUS, 8'h0E);
            rd_chk(OFS_RXDATA, 8'h3C);
            rd_chk(OFS_STATUS, 8'h0C);
            wr_reg(OFS_STATUS, 8'h07);
            rd_chk(OFS_STATUS, 8'h04);
        end
        check({7'h00, dt[1] > dt[0]}, 8'h01);
        wr_reg(OFS_TXDATA, 8'h96);
        frame_wait(dt[0]);
        wr_reg(OFS_STATUS, 8'h00);
        rd_chk(OFS_STATUS, 8'h0E);
        check(btu_rdata, 8'h3C);
        btu_pulse(1'b0, 8'h00);
        rd_chk(OFS_STATUS, 8'h0C);
        btu_pulse(1'b1, 8'hC3);
        frame_wait(dt[0]);
        check(peer_rx, 8'hC3);
        rd_chk(OFS_STATUS, 8'h0E);
        wr_reg(OFS_STATUS, 8'h0D);
        rd_chk(OFS_STATUS, 8'h0C);
        rd_chk(OFS_RXDATA, 8'h3C);
        wr_reg(OFS_TXDATA, 8'h5A);
        rd_chk(OFS_STATUS, 8'h04);
        wr_reg(OFS_STATUS, 8'h0B);
        rd_chk(OFS_STATUS, 8'h00);
        frame_wait(dt[0]);
        check(peer_rx, 8'h5A);
        wr_reg(OFS_ENABLE, 8'h4E);
        rd_chk(OFS_STATUS, 8'h0E);
        complete_run();
    end
endmodule : tb
